/* common/atsw_pkg.sv */
// atsw_pkg: constants, register map and types of the acquisition
// trigger and status block.
// assumes one 125 MHz camera clock and an APB register port.
package atsw_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned ROWS_W = 16;
   localparam int unsigned AVG_W  = 8;
   localparam int unsigned LINES  = 4;
   localparam int unsigned LSEL_W = 2;
   localparam int unsigned SRC_W  = 2;

   // timing figures in ns, converted to whole cycles rounded up
   localparam int unsigned CLK_PERIOD_NS     = 8;
   localparam int unsigned EXP_DELAY_NS      = 23640;
   localparam int unsigned EXP_DELAY_SLOW_NS = 101450;
   localparam int unsigned ROW_TIME_NS       = 8760;
   localparam int unsigned READ_FIXED_NS     = 511570;
   localparam int unsigned ROW_EXTRA         = 1;

   function automatic int unsigned ns_to_cyc(input int unsigned ns);
      return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   endfunction

   localparam int unsigned EXP_DELAY_CYC      = ns_to_cyc(EXP_DELAY_NS);
   localparam int unsigned EXP_DELAY_SLOW_CYC = ns_to_cyc(EXP_DELAY_SLOW_NS);
   localparam int unsigned ROW_CYC            = ns_to_cyc(ROW_TIME_NS);
   localparam int unsigned READ_FIXED_CYC     = ns_to_cyc(READ_FIXED_NS);

   // register byte offsets
   localparam logic [ADDR_W-1:0] REG_CTRL      = 8'h00;
   localparam logic [ADDR_W-1:0] REG_LINE_SEL  = 8'h04;
   localparam logic [ADDR_W-1:0] REG_LINE_SRC  = 8'h08;
   localparam logic [ADDR_W-1:0] REG_FRAME_CNT = 8'h0c;
   localparam logic [ADDR_W-1:0] REG_EXPOSURE  = 8'h10;
   localparam logic [ADDR_W-1:0] REG_ROWS      = 8'h14;
   localparam logic [ADDR_W-1:0] REG_FILTER    = 8'h18;
   localparam logic [ADDR_W-1:0] REG_PAYLOAD   = 8'h1c;
   localparam logic [ADDR_W-1:0] REG_BYTE_PER  = 8'h20;
   localparam logic [ADDR_W-1:0] REG_TX_START  = 8'h24;
   localparam logic [ADDR_W-1:0] REG_AVG_CNT   = 8'h28;
   localparam logic [ADDR_W-1:0] REG_STATUS    = 8'h2c;
   localparam logic [ADDR_W-1:0] REG_INT_STAT  = 8'h30;
   localparam logic [ADDR_W-1:0] REG_INT_CLR   = 8'h34;
   localparam logic [ADDR_W-1:0] REG_INT_EN    = 8'h38;

   // reset values and counter steps
   localparam logic [DATA_W-1:0] RST_FRAME_CNT = 32'h0000_0001;
   localparam logic [DATA_W-1:0] RST_EXPOSURE  = 32'h0000_0400;
   localparam logic [DATA_W-1:0] RST_FILTER    = 32'h0000_0000;
   localparam logic [DATA_W-1:0] RST_PAYLOAD   = 32'h0000_0400;
   localparam logic [DATA_W-1:0] RST_BYTE_PER  = 32'h0000_0001;
   localparam logic [ROWS_W-1:0] RST_ROWS      = 16'h0010;
   localparam logic [ROWS_W-1:0] RST_TX_START  = 16'h0001;
   localparam logic [AVG_W-1:0]  RST_AVG_CNT   = 8'h02;
   localparam logic [DATA_W-1:0] CNT_ONE       = 32'h0000_0001;
   localparam logic [AVG_W:0]    AVG_ONE       = 9'h001;

   // line source codes
   localparam logic [SRC_W-1:0] SRC_LOW  = 2'h0;
   localparam logic [SRC_W-1:0] SRC_WAIT = 2'h1;
   localparam logic [SRC_W-1:0] SRC_HIGH = 2'h2;

   typedef enum logic {
      ACQ_WAIT = 1'b0,
      ACQ_RUN  = 1'b1
   } atsw_acq_e;

   typedef enum logic [2:0] {
      FRM_IDLE   = 3'h0,
      FRM_DELAY  = 3'h1,
      FRM_EXPOSE = 3'h3,
      FRM_READ   = 3'h2,
      FRM_DRAIN  = 3'h6
   } atsw_frm_e;

   typedef struct packed {
      logic frame_ext;
      logic avg_en;
      logic filt_en;
      logic legacy;
      logic enable;
   } atsw_cfg_s;
   localparam int unsigned CFG_W = $bits(atsw_cfg_s);

   typedef struct packed {
      logic frame_sent;
      logic overtrigger;
      logic exposure_end_notice;
      logic frame_start_notice;
      logic acq_start_notice;
   } atsw_evt_s;
   localparam int unsigned EV_W = $bits(atsw_evt_s);

   typedef struct packed {
      logic      tx_busy;
      atsw_acq_e acq_state;
      atsw_frm_e frm_state;
      logic      waiting;
   } atsw_status_s;
endpackage

/* rtl/atsw_acq_ctrl.sv */
// atsw_acq_ctrl: acquisition start wait status, overtrigger check,
// frame sequencing (delay, exposure, readout, transmit) and apb regs.
// assumes one clock pclk; trigger pins are asynchronous.
//
// Chosen here: the APB slave port and the register offsets.
module atsw_acq_ctrl #(
   parameter int unsigned EXP_DELAY_CYC = atsw_pkg::EXP_DELAY_CYC,
   parameter int unsigned ROW_CYC       = atsw_pkg::ROW_CYC,
   parameter int unsigned FIXED_CYC     = atsw_pkg::READ_FIXED_CYC
) (
   input  wire logic                        pclk,    // camera clock
   input  wire logic                        presetn, // async, active low
   input  wire logic                        psel,    // apb select
   input  wire logic                        penable, // apb access phase
   input  wire logic                        pwrite,  // apb direction
   input  wire logic [atsw_pkg::ADDR_W-1:0] paddr,   // apb byte address
   input  wire logic [atsw_pkg::DATA_W-1:0] pwdata,  // apb write data
   output logic      [atsw_pkg::DATA_W-1:0] prdata,  // apb read data
   output logic                             pready,  // apb ready
   output logic                             pslverr, // unmapped address
   input  wire logic          external_acq_start_trigger, // start pin
   input  wire logic          external_trigger_input,     // trigger pin
   output logic [atsw_pkg::LINES-1:0]       out_line,     // lines 1..4
   output logic                             acq_wait_status, // wait level
   output atsw_pkg::atsw_evt_s              notice,       // event pulses
   output logic                             irq,          // level irq
   output logic                             readout_active, // sensor read
   output logic                             tx_active,    // sending frame
   output logic                             tx_byte       // byte pulse
);
   import atsw_pkg::*;

   logic [1:0]        pin_rise;
   atsw_cfg_s         ctrl_reg;
   logic [LSEL_W-1:0] line_sel_reg;
   logic [SRC_W-1:0]  line_src_reg [LINES];
   logic [DATA_W-1:0] frame_cnt_reg;
   logic [DATA_W-1:0] exposure_reg;
   logic [DATA_W-1:0] filter_reg;
   logic [DATA_W-1:0] payload_reg;
   logic [DATA_W-1:0] byte_per_reg;
   logic [ROWS_W-1:0] rows_reg;
   logic [ROWS_W-1:0] tx_start_reg;
   logic [AVG_W-1:0]  avg_cnt_reg;
   logic [EV_W-1:0]   int_stat_reg;
   logic [EV_W-1:0]   int_en_reg;
   logic [EV_W-1:0]   int_stat_next;
   logic [EV_W-1:0]   clr_mask;
   atsw_acq_e         acq_st_reg;
   atsw_acq_e         acq_next;
   atsw_frm_e         frm_st_reg;
   atsw_frm_e         frm_next;
   logic [DATA_W-1:0] cnt_reg;
   logic [DATA_W-1:0] cnt_next;
   logic [ROWS_W:0]   row_reg;
   logic [ROWS_W:0]   row_next;
   logic [ROWS_W:0]   rows_total;
   logic [DATA_W-1:0] frames_left_reg;
   logic [DATA_W-1:0] delay_total;
   logic [DATA_W-1:0] bytes_left_reg;
   logic [DATA_W-1:0] bper_cnt_reg;
   logic [AVG_W-1:0]  avg_idx_reg;
   logic              frm_tx_reg;
   logic              tx_pend_reg;
   logic              tx_on_reg;
   logic [DATA_W-1:0] rd_data;
   logic              rd_err;
   logic [LINES-1:0]  line_next;
   atsw_evt_s         ev;
   atsw_status_s      status_w;

   // both pins pass two flops before any logic sees them
   atsw_sync u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .pin_in  ({external_trigger_input, external_acq_start_trigger}),
      .rise    (pin_rise)
   );

   function automatic logic addr_is(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] off);
      return a == off;
   endfunction

   function automatic logic line_level(input logic [SRC_W-1:0] src,
                                       input logic             lvl);
      return (src == SRC_WAIT) ? lvl : (src == SRC_HIGH);
   endfunction

   // apb decode; access phase is always exactly one cycle
   wire setup    = psel & ~penable;
   wire wr_acc   = psel & penable & pwrite & pready;
   wire wr_ctrl  = wr_acc & addr_is(paddr, REG_CTRL);
   wire wr_lsel  = wr_acc & addr_is(paddr, REG_LINE_SEL);
   wire wr_lsrc  = wr_acc & addr_is(paddr, REG_LINE_SRC);
   wire wr_fcnt  = wr_acc & addr_is(paddr, REG_FRAME_CNT);
   wire wr_exp   = wr_acc & addr_is(paddr, REG_EXPOSURE);
   wire wr_rows  = wr_acc & addr_is(paddr, REG_ROWS);
   wire wr_filt  = wr_acc & addr_is(paddr, REG_FILTER);
   wire wr_pay   = wr_acc & addr_is(paddr, REG_PAYLOAD);
   wire wr_bper  = wr_acc & addr_is(paddr, REG_BYTE_PER);
   wire wr_txs   = wr_acc & addr_is(paddr, REG_TX_START);
   wire wr_avg   = wr_acc & addr_is(paddr, REG_AVG_CNT);
   wire wr_iclr  = wr_acc & addr_is(paddr, REG_INT_CLR);
   wire wr_ien   = wr_acc & addr_is(paddr, REG_INT_EN);

   // trigger roles follow the control mode
   wire acq_trig   = ctrl_reg.legacy ? pin_rise[1] : pin_rise[0];
   wire frame_trig = ~ctrl_reg.legacy & pin_rise[1];
   wire ext_frame  = ctrl_reg.frame_ext & ~ctrl_reg.legacy;

   // wait and overtrigger decisions
   wire acq_waiting = (acq_st_reg == ACQ_WAIT) & ctrl_reg.enable;
   wire acq_accept  = acq_trig & acq_waiting;
   // a trigger outside the wait state is dropped, only flagged
   wire overtrig    = acq_trig & ~acq_waiting;
   wire frm_idle    = (frm_st_reg == FRM_IDLE);
   wire frm_start   = (acq_st_reg == ACQ_RUN) & frm_idle & ctrl_reg.enable
                    & (frames_left_reg != '0)
                    & (ext_frame ? frame_trig : 1'b1);
   wire acq_done    = frm_idle & ((frames_left_reg == '0) | ~ctrl_reg.enable);

   // counter and readout helpers
   wire cnt_end   = (cnt_reg <= CNT_ONE);
   wire exp_end   = (frm_st_reg == FRM_EXPOSE) & cnt_end;
   wire avg_last  = ({1'b0, avg_idx_reg} + AVG_ONE) >= {1'b0, avg_cnt_reg};
   wire tx_this   = ~ctrl_reg.avg_en | avg_last;
   wire bper_end  = (bper_cnt_reg <= CNT_ONE);
   wire byte_tick = tx_on_reg & (bytes_left_reg != '0) & bper_end;
   wire tx_fin    = tx_on_reg & (bytes_left_reg == '0);
   wire tx_idle   = ~tx_pend_reg & ~tx_on_reg;
   // hold sending until the buffer has the start threshold of rows or the readout has ended
   wire tx_go     = tx_pend_reg
                  & (((frm_st_reg == FRM_READ)
                      & (row_reg >= {1'b0, tx_start_reg}))
                     | (frm_st_reg == FRM_DRAIN));
   wire sent      = (frm_st_reg == FRM_DRAIN) & tx_idle;

   // filter time stacks on the fixed exposure start delay
   assign delay_total = DATA_W'(EXP_DELAY_CYC)
                      + (ctrl_reg.filt_en ? filter_reg : '0);
   assign rows_total  = {1'b0, rows_reg} + (ROWS_W+1)'(ROW_EXTRA);

   // acquisition state: waiting re-entered after the last frame
   always_comb begin
      acq_next = acq_st_reg;
      unique case (acq_st_reg)
         ACQ_WAIT: if (acq_accept) acq_next = ACQ_RUN;
         ACQ_RUN:  if (acq_done) acq_next = ACQ_WAIT;
      endcase
   end

   // frame pipeline: delay, exposure, row readout, drain of sending
   always_comb begin
      frm_next = frm_st_reg;
      cnt_next = cnt_end ? '0 : cnt_reg - CNT_ONE;
      row_next = row_reg;
      unique case (frm_st_reg)
         FRM_IDLE: if (frm_start) begin
            frm_next = FRM_DELAY;
            cnt_next = delay_total;
         end
         FRM_DELAY: if (cnt_end) begin
            frm_next = FRM_EXPOSE;
            cnt_next = exposure_reg;
         end
         FRM_EXPOSE: if (cnt_end) begin
            frm_next = FRM_READ;
            cnt_next = DATA_W'(ROW_CYC);
            row_next = '0;
         end
         FRM_READ: if (cnt_end) begin
            if (row_reg < rows_total) begin
               row_next = row_reg + (ROWS_W+1)'(ROW_EXTRA);
               // rows first, then the fixed tail of the readout
               cnt_next = (row_next < rows_total) ? DATA_W'(ROW_CYC)
                                                  : DATA_W'(FIXED_CYC);
            end else begin
               // sending may still run past the readout; drain waits for it to end
               frm_next = frm_tx_reg ? FRM_DRAIN : FRM_IDLE;
            end
         end
         FRM_DRAIN: if (tx_idle) frm_next = FRM_IDLE;
         default: frm_next = FRM_IDLE;
      endcase
   end

   // event vector; trigger edges are single-cycle so one pulse each
   assign ev.acq_start_notice    = acq_accept;
   assign ev.frame_start_notice  = frm_start;
   assign ev.exposure_end_notice = exp_end;
   assign ev.overtrigger         = overtrig;
   assign ev.frame_sent          = sent;

   // sticky status: a set in the same cycle beats the clear
   assign clr_mask      = wr_iclr ? pwdata[EV_W-1:0] : '0;
   assign int_stat_next = (int_stat_reg & ~clr_mask) | ev;

   // status only ever drives pins in standard mode
   wire wait_next = (acq_next == ACQ_WAIT) & ctrl_reg.enable;
   wire wait_pin  = wait_next & ~ctrl_reg.legacy;

   // each line picks its own source
   always_comb begin
      for (int i = 0; i < LINES; i++) begin
         line_next[i] = line_level(line_src_reg[i], wait_pin);
      end
   end

   assign status_w.tx_busy   = tx_on_reg;
   assign status_w.acq_state = acq_st_reg;
   assign status_w.frm_state = frm_st_reg;
   assign status_w.waiting   = acq_waiting;

   // read mux, sampled during the setup phase
   always_comb begin
      rd_data = '0;
      rd_err  = 1'b0;
      case (paddr)
         REG_CTRL:      rd_data = DATA_W'(ctrl_reg);
         REG_LINE_SEL:  rd_data = DATA_W'(line_sel_reg);
         REG_LINE_SRC:  rd_data = DATA_W'(line_src_reg[line_sel_reg]);
         REG_FRAME_CNT: rd_data = frame_cnt_reg;
         REG_EXPOSURE:  rd_data = exposure_reg;
         REG_ROWS:      rd_data = DATA_W'(rows_reg);
         REG_FILTER:    rd_data = filter_reg;
         REG_PAYLOAD:   rd_data = payload_reg;
         REG_BYTE_PER:  rd_data = byte_per_reg;
         REG_TX_START:  rd_data = DATA_W'(tx_start_reg);
         REG_AVG_CNT:   rd_data = DATA_W'(avg_cnt_reg);
         REG_STATUS:    rd_data = DATA_W'(status_w);
         REG_INT_STAT:  rd_data = DATA_W'(int_stat_reg);
         REG_INT_CLR:   rd_data = '0;
         REG_INT_EN:    rd_data = DATA_W'(int_en_reg);
         default:       rd_err  = 1'b1;
      endcase
   end

   // apb answer: data and error latched in setup, ready in access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= '0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         prdata  <= setup ? rd_data : prdata;
         pready  <= setup;
         pslverr <= setup & rd_err;
      end
   end

   // software configuration
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg      <= '{default: 1'b0};
         line_sel_reg  <= '0;
         line_src_reg  <= '{default: SRC_LOW};
         frame_cnt_reg <= RST_FRAME_CNT;
         exposure_reg  <= RST_EXPOSURE;
         filter_reg    <= RST_FILTER;
         payload_reg   <= RST_PAYLOAD;
         byte_per_reg  <= RST_BYTE_PER;
         rows_reg      <= RST_ROWS;
         tx_start_reg  <= RST_TX_START;
         avg_cnt_reg   <= RST_AVG_CNT;
         int_en_reg    <= '0;
      end else begin
         if (wr_ctrl) ctrl_reg <= atsw_cfg_s'(pwdata[CFG_W-1:0]);
         if (wr_lsel) line_sel_reg <= pwdata[LSEL_W-1:0];
         if (wr_lsrc) line_src_reg[line_sel_reg] <= pwdata[SRC_W-1:0];
         if (wr_fcnt) frame_cnt_reg <= pwdata;
         if (wr_exp) exposure_reg <= pwdata;
         if (wr_filt) filter_reg <= pwdata;
         if (wr_pay) payload_reg <= pwdata;
         if (wr_bper) byte_per_reg <= pwdata;
         if (wr_rows) rows_reg <= pwdata[ROWS_W-1:0];
         if (wr_txs) tx_start_reg <= pwdata[ROWS_W-1:0];
         if (wr_avg) avg_cnt_reg <= pwdata[AVG_W-1:0];
         if (wr_ien) int_en_reg <= pwdata[EV_W-1:0];
      end
   end

   // sequencing state; legacy mode runs one frame per start trigger
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acq_st_reg      <= ACQ_WAIT;
         frm_st_reg      <= FRM_IDLE;
         cnt_reg         <= '0;
         row_reg         <= '0;
         frames_left_reg <= '0;
      end else begin
         acq_st_reg <= acq_next;
         frm_st_reg <= frm_next;
         cnt_reg    <= cnt_next;
         row_reg    <= row_next;
         if (acq_accept)
            frames_left_reg <= ctrl_reg.legacy ? CNT_ONE : frame_cnt_reg;
         else if (frm_start)
            frames_left_reg <= frames_left_reg - CNT_ONE;
      end
   end

   // averaging and send bookkeeping, decided at exposure end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         avg_idx_reg    <= '0;
         frm_tx_reg     <= 1'b0;
         tx_pend_reg    <= 1'b0;
         tx_on_reg      <= 1'b0;
         bytes_left_reg <= '0;
         bper_cnt_reg   <= '0;
      end else begin
         if (exp_end) begin
            avg_idx_reg <= (~ctrl_reg.avg_en | avg_last) ? '0
                           : avg_idx_reg + AVG_W'(ROW_EXTRA);
            frm_tx_reg  <= tx_this;
         end
         tx_pend_reg <= (exp_end & tx_this) | (tx_pend_reg & ~tx_go);
         tx_on_reg   <= tx_go | (tx_on_reg & ~tx_fin);
         if (tx_go)
            bytes_left_reg <= payload_reg;
         else if (byte_tick)
            bytes_left_reg <= bytes_left_reg - CNT_ONE;
         // byte pacing stands in for the link byte rate
         if (tx_go | byte_tick)
            bper_cnt_reg <= byte_per_reg;
         else if (!bper_end)
            bper_cnt_reg <= bper_cnt_reg - CNT_ONE;
      end
   end

   // registered outputs; the wait flop falls on the accepting edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acq_wait_status <= 1'b0;
         out_line        <= '0;
         notice          <= '{default: 1'b0};
         int_stat_reg    <= '0;
         irq             <= 1'b0;
         readout_active  <= 1'b0;
         tx_byte         <= 1'b0;
      end else begin
         acq_wait_status <= wait_pin;
         out_line        <= line_next;
         notice          <= ev;
         int_stat_reg    <= int_stat_next;
         irq             <= |(int_stat_next & int_en_reg);
         readout_active  <= (frm_next == FRM_READ);
         tx_byte         <= byte_tick;
      end
   end

   assign tx_active = tx_on_reg;
endmodule

/* rtl/atsw_sync.sv */
// atsw_sync: two-flop synchroniser and rising-edge detect for the
// two trigger pins.
// assumes pins are asynchronous to pclk and stay high over 2 cycles.
module atsw_sync (
   input  wire logic       pclk,    // camera clock
   input  wire logic       presetn, // async reset, active low
   input  wire logic [1:0] pin_in,  // raw trigger pins
   output logic      [1:0] rise     // one-cycle pulse per rising edge
);
   logic [1:0] meta_reg;
   logic [1:0] sync_reg;
   logic [1:0] prev_reg;

   // meta stage feeds only the second stage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_reg <= 2'h0;
         sync_reg <= 2'h0;
         prev_reg <= 2'h0;
      end else begin
         meta_reg <= pin_in;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   // edge from the settled stages only
   assign rise = sync_reg & ~prev_reg;
endmodule

/* tb/atsw_chk.sv */
// atsw_chk: port-level assertions for atsw_acq_ctrl.
// assumes one clock pclk and the async active-low presetn.
module atsw_chk
   import atsw_pkg::*;
(
   input wire logic                pclk,            // clock
   input wire logic                presetn,         // reset
   input wire logic                psel,            // apb select
   input wire logic                penable,         // apb access
   input wire logic                pready,          // apb ready
   input wire logic                pslverr,         // apb error
   input wire logic                acq_wait_status, // wait level
   input wire atsw_pkg::atsw_evt_s notice,          // event pulses
   input wire logic                readout_active,  // sensor read
   input wire logic                tx_active        // sending
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // a taken start leaves the wait level low in that same cycle
   a_wait_fall: assert property (
      notice.acq_start_notice |-> !acq_wait_status)
      else $error("wait high after start taken");
   a_ovt_single: assert property (
      notice.overtrigger |=> !notice.overtrigger)
      else $error("overtrigger pulse too long");
   a_ovt_dropped: assert property (
      notice.overtrigger |-> !notice.acq_start_notice)
      else $error("dropped trigger also started");
   a_exp_readout: assert property (
      notice.exposure_end_notice |-> ##[0:2] readout_active)
      else $error("no readout after exposure");
   a_tx_buffered: assert property (
      $rose(tx_active) |-> readout_active)
      else $error("sending began outside readout");
   a_sent_done: assert property (
      notice.frame_sent |-> !readout_active && !tx_active)
      else $error("frame sent before readout end");
   // one wait-free access cycle on the register port
   a_apb_answer: assert property (
      psel && !penable |=> pready)
      else $error("no ready in access cycle");
   a_err_ready: assert property (
      pslverr |-> pready && $past(psel))
      else $error("error without ready");
   cover property (notice.overtrigger);
   cover property (notice.frame_sent);
   cover property (pslverr);
endmodule
bind atsw_acq_ctrl atsw_chk chk_u (.pclk, .presetn, .psel, .penable,
   .pready, .pslverr, .acq_wait_status, .notice, .readout_active,
   .tx_active);

/* tb/atsw_far.sv */
// atsw_far: trigger source and host byte receiver.
// assumes the bench decides when firing is allowed.
module atsw_far (
   input  wire logic       pclk,    // camera clock
   input  wire logic       tx_byte, // byte pulse from the block
   output logic      [1:0] pin,     // bit0 start pin, bit1 trigger pin
   output int              nbytes   // bytes taken by the host
);
   timeunit 1ns;
   timeprecision 1ps;
   initial pin = 2'h0;
   initial nbytes = 0;
   // host counts every byte pulse
   always @(posedge pclk) if (tx_byte === 1'b1) nbytes <= nbytes + 1;
   // held past the two-flop sync so the edge is never lost
   task automatic fire(input int i);
      @(posedge pclk);
      pin[i] <= 1'b1;
      repeat (4) @(posedge pclk);
      pin[i] <= 1'b0;
      repeat (4) @(posedge pclk);
   endtask
endmodule

/* tb/tb_acquisition_trigger_status.sv */
// tb_acquisition_trigger_status: self-checking bench for atsw_acq_ctrl.
// assumes the bound checker and atsw_far on the pins.
module tb_acquisition_trigger_status;
   timeunit 1ns;
   timeprecision 1ps;
   import atsw_pkg::*;
   logic        pclk = 0, presetn = 0, psel, penable, pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, r;
   logic        pready, pslverr, acq_wait_status, irq, er;
   logic        readout_active, tx_active, tx_byte;
   logic [3:0]  out_line;
   logic [1:0]  pin;
   atsw_evt_s   notice;
   int          miscompares = 0, comparisons = 0, nbytes, n[5], lat;
   always #4 pclk = ~pclk;
   // tally each notice pulse; lat counts cycles since the frame start notice
   always @(posedge pclk) begin
      for (int i = 0; i < 5; i++) n[i] += notice[i];
      lat <= notice.frame_start_notice ? 1 : lat + 1;
   end
   atsw_acq_ctrl #(.EXP_DELAY_CYC(4), .ROW_CYC(3), .FIXED_CYC(5)) dut_u (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .external_acq_start_trigger(pin[0]),
      .external_trigger_input(pin[1]), .out_line, .acq_wait_status,
      .notice, .irq, .readout_active, .tx_active, .tx_byte);
   atsw_far src_u (.pclk, .tx_byte, .pin, .nbytes);
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one apb transfer; result lands in r and er
   task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wt(logic v);
      int k;
      k = 0;
      while (acq_wait_status !== v && k < 3000) begin
         @(posedge pclk);
         k++;
      end
      chk("wait status", 32'(v), 32'(acq_wait_status));
   endtask
   task automatic t_regs();
      apb(0, REG_EXPOSURE, 0);
      chk("exposure", RST_EXPOSURE, r);
      apb(1, 8'h3c, 32'h5);
      chk("unmapped err", 1, 32'(er));
      apb(0, 8'h3c, 0);
      chk("unmapped data", 0, r);
   endtask
   task automatic t_lines();
      apb(1, REG_CTRL, 32'h1);
      wt(1);
      for (int i = 0; i < 4; i++) begin
         apb(1, REG_LINE_SEL, i);
         apb(1, REG_LINE_SRC, 32'(SRC_WAIT));
         repeat (2) @(posedge pclk);
         chk("line", 32'h1 << i, 32'(out_line));
         apb(1, REG_LINE_SRC, 32'(SRC_LOW));
      end
      apb(1, REG_LINE_SRC, 32'(SRC_WAIT));
      apb(1, REG_CTRL, 32'h3);
      repeat (2) @(posedge pclk);
      chk("legacy wait", 0, 32'({acq_wait_status, out_line}));
      apb(1, REG_CTRL, 32'h1);
   endtask
   task automatic t_run();
      int b;
      b = nbytes;
      n = '{default: 0};
      wt(1);
      src_u.fire(0);
      chk("wait taken", 0, 32'(acq_wait_status));
      src_u.fire(0);
      wt(1);
      chk("notices", 32'h11111, {n[4][3:0], n[3][3:0], n[2][3:0],
         n[1][3:0], n[0][3:0]});
      chk("bytes", 4, nbytes - b);
   endtask
   task automatic t_avg();
      apb(1, REG_CTRL, 32'h9);
      n = '{default: 0};
      src_u.fire(0);
      wt(1);
      chk("averaged", 32'h10220, {n[4][3:0], n[3][3:0], n[2][3:0],
         n[1][3:0], 4'h0});
   endtask
   // external frame start plus filter: 4 delay + 6 filter + 4 exposure
   task automatic t_ext();
      apb(1, REG_FILTER, 32'h6);
      apb(1, REG_CTRL, 32'h15);
      n = '{default: 0};
      src_u.fire(0);
      chk("held frame", 0, n[1]);
      src_u.fire(1);
      while (notice.exposure_end_notice !== 1'b1) @(posedge pclk);
      chk("start delay", 32'd14, lat);
      wt(1);
      chk("ext frames", 1, n[1]);
   endtask
   task automatic t_irq();
      apb(0, REG_INT_STAT, 0);
      chk("int stat", 32'h1f, r);
      apb(1, REG_INT_CLR, 32'h1f);
      apb(1, REG_INT_EN, 32'h0);
      apb(1, REG_CTRL, 32'h0);
      src_u.fire(0);
      apb(0, REG_INT_STAT, 0);
      chk("masked", 32'h80, {r[27:0], irq, 3'h0});
      apb(1, REG_INT_EN, 32'h8);
      repeat (2) @(posedge pclk);
      chk("irq on", 1, 32'(irq));
      apb(1, REG_INT_CLR, 32'h8);
      repeat (2) @(posedge pclk);
      chk("irq off", 0, 32'(irq));
   endtask
   task automatic t_legacy();
      int k;
      apb(1, REG_CTRL, 32'h3);
      n = '{default: 0};
      src_u.fire(1);
      for (k = 0; k < 3000 && n[4] == 0; k++) @(posedge pclk);
      chk("legacy start", 32'h101, {n[4][3:0], 4'h0, n[0][3:0]});
      chk("legacy level", 0, 32'(acq_wait_status));
   endtask
   task automatic summarize();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      {psel, penable, pwrite, paddr, pwdata} <= '0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_lines();
      apb(1, REG_EXPOSURE, 32'h4);
      apb(1, REG_ROWS, 32'h2);
      apb(1, REG_PAYLOAD, 32'h4);
      apb(1, REG_BYTE_PER, 32'h2);
      apb(1, REG_FRAME_CNT, 32'h2);
      apb(1, REG_INT_EN, 32'h1f);
      t_avg();
      apb(1, REG_CTRL, 32'h1);
      apb(1, REG_FRAME_CNT, 32'h1);
      t_run();
      t_ext();
      t_irq();
      t_legacy();
      summarize();
   end
   // watchdog far beyond the few hundred cycles the tests need
   initial begin
      #100000;
      miscompares++;
      summarize();
   end
endmodule
